// file: interrupt_priority_fields.v
// Overview of operation
// - Field value is the priority level; 7 highest, 1 lowest.
// - A field of zero disables its source; it never requests service.
// - CRC/UART register bits 15, 11, 7, 3-0 store nothing, read zero.
// - Every field resets to level four and is readable and writable.
// - CRC error priority sits in bits 14-12.
// - Second UART error priority sits in bits 10-8.
// - First UART error priority sits in bits 6-4.

`timescale 1ns/100ps
`default_nettype none

module interrupt_priority_fields (
   input wire clk_i,
   input wire rst_b_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg wb_err_o,
   output wire [2:0] ext_irq_four_prio_o,
   output wire [2:0] ext_irq_three_prio_o,
   output wire [2:0] clock_calendar_prio_o,
   output wire [2:0] dma_channel_five_prio_o,
   output wire [2:0] checksum_error_prio_o,
   output wire [2:0] serial_two_error_prio_o,
   output wire [2:0] serial_one_error_prio_o,
   output wire [6:0] source_enabled_o
);

`include "prio_defs.vh"

   // Number of priority fields, in the order of the output ports.
   localparam NF = 7;

   // Handshake states of the register port. The answer always comes one
   // cycle after the request is taken, so two states are enough.
   localparam ST_IDLE = 1'b0;
   localparam ST_RESP = 1'b1;

   // Register index and field position for each field, in port order.
   function [1:0] fld_reg;
      input integer k;
      begin
         case (k)
            0: fld_reg = `EXT_INT_3_4_PRIORITY_IDX;
            1: fld_reg = `EXT_INT_3_4_PRIORITY_IDX;
            2: fld_reg = `RTC_DMA5_PRIORITY_IDX;
            3: fld_reg = `RTC_DMA5_PRIORITY_IDX;
            default: fld_reg = `CRC_UART_ERROR_PRIORITY_IDX;
         endcase
      end
   endfunction

   function integer fld_lsb;
      input integer k;
      begin
         case (k)
            0: fld_lsb = `EXT_IRQ_FOUR_PRIO_LSB;
            1: fld_lsb = `EXT_IRQ_THREE_PRIO_LSB;
            2: fld_lsb = `CLOCK_CALENDAR_PRIO_LSB;
            3: fld_lsb = `DMA_CHANNEL_FIVE_PRIO_LSB;
            4: fld_lsb = `CHECKSUM_ERROR_PRIO_LSB;
            5: fld_lsb = `SERIAL_TWO_ERROR_PRIO_LSB;
            default: fld_lsb = `SERIAL_ONE_ERROR_PRIO_LSB;
         endcase
      end
   endfunction

   // Byte lane that carries a field; a field never straddles two lanes.
   function integer fld_lane;
      input integer k;
      begin
         fld_lane = fld_lsb(k) / 8;
      end
   endfunction

   // Fields are kept flat, three bits each, in port order.
   wire [1:0] idx;
   wire take;
   wire [3*NF-1:0] prio_flat;
   wire [NF-1:0] en;
   reg [2:0] hit;
   reg mapped;
   reg [15:0] rd_word;
   reg state_q;
   reg state_d;
   reg ack_d;
   reg err_d;
   reg [31:0] dat_d;

   assign idx = wb_adr_i[3:2];

   // Address decode. Only the word-aligned offsets of the three registers
   // are mapped; anything else is answered with an error so that a stray
   // pointer in software shows up instead of reading silent zeros.
   always @* begin
      hit = 3'h0;
      mapped = 1'b0;
      if (wb_adr_i[1:0] != 2'h0) begin
         mapped = 1'b0;
      end else if (idx == `EXT_INT_3_4_PRIORITY_IDX) begin
         hit[`EXT_INT_3_4_PRIORITY_IDX] = 1'b1;
         mapped = 1'b1;
      end else if (idx == `RTC_DMA5_PRIORITY_IDX) begin
         hit[`RTC_DMA5_PRIORITY_IDX] = 1'b1;
         mapped = 1'b1;
      end else if (idx == `CRC_UART_ERROR_PRIORITY_IDX) begin
         hit[`CRC_UART_ERROR_PRIORITY_IDX] = 1'b1;
         mapped = 1'b1;
      end
   end

   // A request is taken only from the idle state, so a strobe that the
   // master still holds in the cycle of the answer is not taken twice.
   // The error answer uses the same state, so ack and err never overlap.
   assign take = wb_cyc_i && wb_stb_i && (state_q == ST_IDLE);

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (wb_cyc_i && wb_stb_i) begin
               state_d = ST_RESP;
            end
         end
         ST_RESP: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // One storage module per field. A write changes a field at the edge
   // that takes the request, so arbitration sees it in the next cycle.
   genvar g;
   generate
      for (g = 0; g < NF; g = g + 1) begin : fields
         // Only whole fields are written; bits between fields have no
         // storage, so writes to them are simply dropped.
         wire wr;
         assign wr = take && wb_we_i && hit[fld_reg(g)] &&
            wb_sel_i[fld_lane(g)];
         prio_field u_field (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .wr_i(wr),
            .wdata_i(wb_dat_i[fld_lsb(g) +: 3]),
            .prio_o(prio_flat[3*g +: 3]),
            .active_o(en[g])
         );
      end
   endgenerate

   // Field values go straight to arbitration; level equals value.
   // No gate lies between a field's flip-flops and its output.
   assign ext_irq_four_prio_o = prio_flat[2:0];
   assign ext_irq_three_prio_o = prio_flat[5:3];
   assign clock_calendar_prio_o = prio_flat[8:6];
   assign dma_channel_five_prio_o = prio_flat[11:9];
   assign checksum_error_prio_o = prio_flat[14:12];
   assign serial_two_error_prio_o = prio_flat[17:15];
   assign serial_one_error_prio_o = prio_flat[20:18];
   assign source_enabled_o = en;

   // Read mux. Fields of a register that is not addressed add nothing,
   // and unimplemented bits stay at the zero given at the top.
   integer k;
   always @* begin
      rd_word = 16'h0000;
      for (k = 0; k < NF; k = k + 1) begin
         if (hit[fld_reg(k)]) begin
            rd_word[fld_lsb(k) +: 3] = prio_flat[3*k +: 3];
         end
      end
   end

   // Next values of the answer. Read data stands only in the cycle of the
   // acknowledge and is zero otherwise, which keeps a shared read bus
   // free of stale words.
   always @* begin
      ack_d = 1'b0;
      err_d = 1'b0;
      dat_d = 32'h00000000;
      if (take) begin
         if (mapped) begin
            ack_d = 1'b1;
            if (!wb_we_i) begin
               dat_d = {16'h0000, rd_word};
            end
         end else begin
            err_d = 1'b1;
         end
      end
   end

   // The answer and the handshake state leave from flip-flops; a reset
   // in mid-transfer simply drops the pending answer.
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         state_q <= ST_IDLE;
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         state_q <= state_d;
         wb_ack_o <= ack_d;
         wb_err_o <= err_d;
         wb_dat_o <= dat_d;
      end
   end

endmodule // interrupt_priority_fields

`default_nettype wire

// file: prio_defs.vh
`ifndef PRIO_DEFS_VH
`define PRIO_DEFS_VH

// Register word addresses (byte address = 4 * index).
`define EXT_INT_3_4_PRIORITY_IDX 2'h0
`define RTC_DMA5_PRIORITY_IDX 2'h1
`define CRC_UART_ERROR_PRIORITY_IDX 2'h2

// Field positions (least significant bit of each 3-bit field).
`define EXT_IRQ_FOUR_PRIO_LSB 8
`define EXT_IRQ_THREE_PRIO_LSB 4
`define CLOCK_CALENDAR_PRIO_LSB 8
`define DMA_CHANNEL_FIVE_PRIO_LSB 4
`define CHECKSUM_ERROR_PRIO_LSB 12
`define SERIAL_TWO_ERROR_PRIO_LSB 8
`define SERIAL_ONE_ERROR_PRIO_LSB 4

// Field encodings and reset value.
`define PRIO_RESET 3'h4
`define PRIO_DISABLED 3'h0
`define PRIO_HIGHEST 3'h7
`define PRIO_LOWEST 3'h1

`endif

// file: prio_field.v
`timescale 1ns/100ps
`default_nettype none

// One 3-bit priority field with its own storage and reset value.
module prio_field (
   input wire clk_i,
   input wire rst_b_i,
   input wire wr_i,
   input wire [2:0] wdata_i,
   output wire [2:0] prio_o,
   output wire active_o
);

`include "prio_defs.vh"

   reg [2:0] prio_q;
   reg active_q;

   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         prio_q <= `PRIO_RESET;
         active_q <= 1'b1;
      end else if (wr_i) begin
         prio_q <= wdata_i;
         active_q <= (wdata_i != `PRIO_DISABLED);
      end
   end

   assign prio_o = prio_q;
   assign active_o = active_q;

endmodule // prio_field

`default_nettype wire

// file: prio_props.sv
`timescale 1ns/100ps
`default_nettype none
module prio_props (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic [2:0] checksum_error_prio_o,
   input wire logic [2:0] serial_two_error_prio_o,
   input wire logic [2:0] serial_one_error_prio_o,
   input wire logic [6:0] source_enabled_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   wire wr8 = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o
      && wb_adr_i == 4'h8;
   sequence take_hi; wr8 && wb_sel_i[1]; endsequence
   sequence take_lo; wr8 && wb_sel_i[0]; endsequence
   a_crc_write: assert property (take_hi |=>
      checksum_error_prio_o == $past(wb_dat_i[14:12])) else $error("crc");
   a_uart2_write: assert property (take_hi |=>
      serial_two_error_prio_o == $past(wb_dat_i[10:8])) else $error("u2");
   a_uart1_write: assert property (take_lo |=>
      serial_one_error_prio_o == $past(wb_dat_i[6:4])) else $error("u1");
   a_zero_bits: assert property (wb_ack_o |->
      (wb_dat_o & 32'hFFFF888F) == 32'h0) else $error("unused bits");
   a_read_back: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == 4'h8
      |-> wb_dat_o[6:4] == serial_one_error_prio_o) else $error("level");
   a_off_flag: assert property (
      source_enabled_o[4] == (checksum_error_prio_o != 3'h0))
      else $error("off");
   a_reset_level: assert property ($rose(rst_b_i) |->
      serial_two_error_prio_o == 3'h4 && source_enabled_o == 7'h7F)
      else $error("reset level");
   a_hold_value: assert property (!wr8 |=>
      $stable(serial_one_error_prio_o)) else $error("hold");
endmodule // prio_props
bind interrupt_priority_fields prio_props prio_props_inst (
   .clk_i(clk_i),
   .rst_b_i(rst_b_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o),
   .checksum_error_prio_o(checksum_error_prio_o),
   .serial_two_error_prio_o(serial_two_error_prio_o),
   .serial_one_error_prio_o(serial_one_error_prio_o),
   .source_enabled_o(source_enabled_o)
);
`default_nettype wire

// file: interrupt_priority_fields_test.sv
`timescale 1ns/100ps
`default_nettype none
module interrupt_priority_fields_test;
logic clk_i = 1'h0, rst_b_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
logic wb_we_i = 1'h0, er;
logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
logic [31:0] wb_dat_i = 32'h0, rd;
wire [31:0] wb_dat_o;
wire wb_ack_o, wb_err_o;
wire [2:0] ext_irq_four_prio_o, ext_irq_three_prio_o, clock_calendar_prio_o;
wire [2:0] dma_channel_five_prio_o, checksum_error_prio_o;
wire [2:0] serial_two_error_prio_o, serial_one_error_prio_o;
wire [6:0] source_enabled_o;
integer err_total = 0, total_checks = 0;
interrupt_priority_fields interrupt_priority_fields_inst (
   .clk_i(clk_i),
   .rst_b_i(rst_b_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o),
   .ext_irq_four_prio_o(ext_irq_four_prio_o),
   .ext_irq_three_prio_o(ext_irq_three_prio_o),
   .clock_calendar_prio_o(clock_calendar_prio_o),
   .dma_channel_five_prio_o(dma_channel_five_prio_o),
   .checksum_error_prio_o(checksum_error_prio_o),
   .serial_two_error_prio_o(serial_two_error_prio_o),
   .serial_one_error_prio_o(serial_one_error_prio_o),
   .source_enabled_o(source_enabled_o)
);
initial forever #5 clk_i = ~clk_i;
task chk(input logic [31:0] s, e);
   total_checks++;
   if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: %h not %h", $time, s, e);
   end
endtask
task bus(input logic w, input logic [3:0] a, s, input logic [15:0] d);
   {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <=
      {2'h3, w, a, s, 16'h0, d};
   do @(posedge clk_i); while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1);
   rd = wb_dat_o;
   er = wb_err_o;
   // Idle for one cycle so the slave cannot retake a held request.
   {wb_cyc_i, wb_stb_i} <= 2'h0;
   @(posedge clk_i);
endtask
task t_reset;
   bus(1'h0, 4'h0, 4'hF, 16'h0);
   chk(rd, 32'h440);
   bus(1'h0, 4'h4, 4'hF, 16'h0);
   chk(rd, 32'h440);
   chk(32'(ext_irq_three_prio_o), 32'h4);
   chk(32'(clock_calendar_prio_o), 32'h4);
   chk(32'(dma_channel_five_prio_o), 32'h4);
   bus(1'h0, 4'h8, 4'hF, 16'h0);
   chk(rd, 32'h4440);
endtask
task t_mask;
   bus(1'h1, 4'h8, 4'hF, 16'hFFFF);
   bus(1'h0, 4'h8, 4'hF, 16'h0);
   chk(rd, 32'h7770);
   chk(32'(checksum_error_prio_o), 32'h7);
endtask
task t_levels;
   for (int i = 0; i < 8; i++) begin
      bus(1'h1, 4'h8, 4'h1, {9'h0, i[2:0], 4'h0});
      chk(32'(serial_one_error_prio_o), i);
      chk(32'(source_enabled_o[6]), 32'(i != 0));
   end
endtask
task t_lane;
   bus(1'h0, 4'h8, 4'hF, 16'h0);
   chk(rd, 32'h7770);
   chk(32'(serial_two_error_prio_o), 32'h7);
   bus(1'h1, 4'h8, 4'h2, 16'h2350);
   bus(1'h0, 4'h8, 4'hF, 16'h0);
   chk(rd, 32'h2370);
   chk(32'(serial_two_error_prio_o), 32'h3);
   chk(32'(checksum_error_prio_o), 32'h2);
   chk(32'(serial_one_error_prio_o), 32'h7);
endtask
task t_mid;
   bus(1'h1, 4'h4, 4'h3, 16'h0500);
   bus(1'h0, 4'h4, 4'hF, 16'h0);
   chk(rd, 32'h500);
   chk(32'(clock_calendar_prio_o), 32'h5);
   chk(32'(dma_channel_five_prio_o), 32'h0);
   chk(32'(source_enabled_o[3]), 32'h0);
endtask
task t_unmap;
   bus(1'h1, 4'hC, 4'h3, 16'h0);
   chk(32'(er), 32'h1);
   chk(32'(ext_irq_four_prio_o), 32'h4);
   bus(1'h1, 4'h0, 4'h3, 16'h0);
   chk(32'(source_enabled_o), 32'h74);
   chk(32'(ext_irq_three_prio_o), 32'h0);
endtask
task close_out;
   $display("checks %0d errors %0d", total_checks, err_total);
   if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
   else $display("CHECKS NOT OK");
   $finish;
endtask
initial begin
   repeat (3000) @(posedge clk_i);
   err_total++;
   close_out;
end
initial begin
   repeat (4) @(posedge clk_i);
   rst_b_i <= 1'h1;
   @(posedge clk_i);
   t_reset;
   t_mask;
   t_levels;
   t_lane;
   t_mid;
   t_unmap;
   close_out;
end
endmodule // interrupt_priority_fields_test
`default_nettype wire
